// ---- hw/eag_defs.svh ----
/*
 * Field positions, encodings, register offsets and bit positions for the
 * effective-address generator.
 * Assumes inclusion by bare name from design files only.
 */
`ifndef EAG_DEFS_SVH
`define EAG_DEFS_SVH
// ea specifier in the instruction word
`define EAG_F_MODE   5:3
`define EAG_F_REG    2:0
`define EAG_M_DREG   3'h0
`define EAG_M_AREG   3'h1
`define EAG_M_IND    3'h2
`define EAG_M_POST   3'h3
`define EAG_M_PRE    3'h4
`define EAG_M_DISP   3'h5
`define EAG_M_INDEX  3'h6
`define EAG_M_SPEC   3'h7
`define EAG_S_ABSW   3'h0
`define EAG_S_ABSL   3'h1
`define EAG_S_PCD    3'h2
`define EAG_S_PCX    3'h3
`define EAG_S_IMM    3'h4
`define EAG_SP_REG   3'h7
// extension word fields
`define EAG_X_REG    15:12
`define EAG_X_WL     11
`define EAG_X_SC     10:9
`define EAG_X_FULL   8
`define EAG_X_BS     7
`define EAG_X_IS     6
`define EAG_X_BDSZ   5:4
`define EAG_X_IIS    2:0
`define EAG_X_D8     7:0
`define EAG_SZ_NULL  2'h1
`define EAG_SZ_WORD  2'h2
`define EAG_SZ_LONG  2'h3
`define EAG_SZ_RSV   2'h0
`define EAG_IIS_RSV  3'h4
// register offsets
`define EAG_A_CTRL   8'h00
`define EAG_A_OPW    8'h04
`define EAG_A_PC     8'h08
`define EAG_A_STAT   8'h0c
`define EAG_A_EA     8'h10
`define EAG_A_IMM    8'h14
`define EAG_A_UPD    8'h18
`define EAG_A_EXT    8'h20
`define EAG_A_GPR    8'h40
// control and status bits
`define EAG_C_GO     0
`define EAG_C_WR     1
`define EAG_C_SIZE   3:2
`define EAG_C_START  6:4
`define EAG_ST_BUSY  0
`define EAG_ST_DONE  1
`define EAG_ST_FAULT 2
`define EAG_ST_PROG  3
`define EAG_ST_REG   4
`define EAG_ST_IND   5
`define EAG_ST_CLS   9:6
`define EAG_ST_NW    12:10
`endif

// ---- hw/eag_pkg.sv ----
/*
 * Types shared by the effective-address generator modules.
 * Assumes eag_defs.svh for numeric constants.
 */
package eag_pkg;
  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} eag_size_t;
  typedef enum logic [1:0] {ST_IDLE, ST_CALC, ST_PTR} eag_state_t;
  typedef struct packed {
    logic data;
    logic memory;
    logic control;
    logic alterable;
  } eag_cls_t;
endpackage : eag_pkg

// ---- hw/eag_dec_if.sv ----
/*
 * Carrier between the core of the generator and its index and class units.
 * Assumes all users sit on one clock; signals are combinational.
 */
`timescale 1ns/1ns
interface eag_dec_if;
  logic [15:0]       ext;
  logic [31:0]       xval;
  logic [31:0]       idx;
  logic [2:0]        mode;
  logic [2:0]        regf;
  eag_pkg::eag_cls_t cls;
  modport core (output ext, xval, mode, regf, input idx, cls);
  modport idx_unit (input ext, xval, output idx);
  modport cls_unit (input mode, regf, output cls);
endinterface : eag_dec_if

// ---- hw/eag_index.sv ----
/*
 * Index operand: size selection and scaling of the chosen index register.
 * Assumes the core supplies the register value picked by the extension word.
 */
`timescale 1ns/1ns
`include "eag_defs.svh"
module eag_index (
  // decode carrier
  eag_dec_if.idx_unit d
);
  import eag_pkg::*;
  logic [31:0] sized;
  always_comb begin
    sized = d.ext[`EAG_X_WL] ? d.xval : {{16{d.xval[15]}}, d.xval[15:0]};
    d.idx = sized << d.ext[`EAG_X_SC];
  end
endmodule : eag_index

// ---- hw/eag_classify.sv ----
/*
 * Addressing category of a mode: data, memory, control, alterable.
 * Assumes mode and register fields straight from the instruction word.
 */
`timescale 1ns/1ns
`include "eag_defs.svh"
module eag_classify (
  // decode carrier
  eag_dec_if.cls_unit d
);
  import eag_pkg::*;
  always_comb begin
    case (d.mode)
      `EAG_M_DREG: d.cls = '{1'b1, 1'b0, 1'b0, 1'b1};
      `EAG_M_AREG: d.cls = '{1'b0, 1'b0, 1'b0, 1'b1};
      `EAG_M_POST,
      `EAG_M_PRE:  d.cls = '{1'b1, 1'b1, 1'b0, 1'b1};
      `EAG_M_SPEC: begin
        case (d.regf)
          `EAG_S_ABSW,
          `EAG_S_ABSL: d.cls = '{1'b1, 1'b1, 1'b1, 1'b1};
          `EAG_S_PCD,
          `EAG_S_PCX:  d.cls = '{1'b1, 1'b0, 1'b1, 1'b1};
          `EAG_S_IMM:  d.cls = '{1'b1, 1'b1, 1'b0, 1'b0};
          default:     d.cls = '0;
        endcase
      end
      default:     d.cls = '{1'b1, 1'b1, 1'b1, 1'b1};
    endcase
  end
endmodule : eag_classify

// ---- hw/eag_top.sv ----
/*
 * Effective-address generator: decodes one ea specifier and its extension
 * words, forms the operand address, tags program space and read-only use,
 * and fetches a pointer for memory-indirect forms.
 * Assumes a classic Wishbone master and a same-clock pointer read port.
 */
// Notes on behaviour
// - mode 111: register field picks submode
// - pc disp: pc is extension word address
// - pc-relative is program space, reads only
// - pc brief index: pc+disp8+scaled index
// - pc full index: first extension address base
// - pc, index, displacement each suppressible
// - absolute short sign-extended to 32 bits
// - absolute long: high word first
// - immediate byte, word, long from extensions
// - modes 000-110 use register field
// - brief/full told apart by extension format
// - up to six extension words held
// - base suppress drops base register
// - index word sign-extended or long
// - scale shifts index copy only
// - scaling costs no extra cycles
// - indirect: fetch pointer, then add outer disp (and index if post)
// - base displacement full 32 bits wide
// - modes classed data/memory/control/alterable
// - specifier: 3-bit mode, 3-bit register
// - index word: d/a, number, size, scale
`timescale 1ns/1ns
`include "eag_defs.svh"
module eag_top (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // wishbone slave
  input  wire logic        wb_cyc,
  input  wire logic        wb_stb,
  input  wire logic        wb_we,
  input  wire logic [7:0]  wb_adr,
  input  wire logic [3:0]  wb_sel,
  input  wire logic [31:0] wb_wdata,
  output      logic [31:0] wb_rdata,
  output      logic        wb_ack,
  // pointer fetch
  output      logic        ptr_req,
  output      logic [31:0] ptr_addr,
  input  wire logic        ptr_ack,
  input  wire logic [31:0] ptr_data,
  // operand access unit
  output      logic        ea_valid,
  output      logic [31:0] ea_addr,
  output      logic        ea_prog,
  output      logic        ea_fault
);
  import eag_pkg::*;

  localparam int NEXT = 6;
  localparam int NGPR = 16;

  // operand registers
  logic [31:0] gpr_q [NGPR];
  logic [15:0] ext_q [NEXT];
  logic [5:0]  opw_q;
  logic [31:0] pc_q;
  logic        wr_q;
  eag_size_t   size_q;
  logic [2:0]  start_q;
  // results
  eag_state_t  state_q;
  logic [31:0] ea_q;
  logic [31:0] imm_q;
  logic [31:0] upd_q;
  logic [31:0] add_q;
  logic        done_q;
  logic        fault_q;
  logic        prog_q;
  logic        isreg_q;
  logic        ind_q;
  eag_cls_t    cls_q;
  logic [2:0]  nw_q;

  eag_dec_if dec ();

  eag_index    u_index    (.d(dec));
  eag_classify u_classify (.d(dec));

  function automatic logic [31:0] sext16(input logic [15:0] v);
    sext16 = {{16{v[15]}}, v};
  endfunction : sext16

  function automatic logic [31:0] sext8(input logic [7:0] v);
    sext8 = {{24{v[7]}}, v};
  endfunction : sext8

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  sel);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = sel[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction : merge

  // extension word k of this specifier, zero past the last slot
  function automatic logic [15:0] ext_at(input logic [2:0] k);
    logic [3:0] i;
    i = {1'b0, start_q} + {1'b0, k};
    ext_at = (i < 4'(NEXT)) ? ext_q[i[2:0]] : 16'h0000;
  endfunction : ext_at

  logic [2:0]  mode;
  logic [2:0]  regf;
  assign mode = opw_q[`EAG_F_MODE];
  assign regf = opw_q[`EAG_F_REG];

  logic [15:0] e0;
  logic [15:0] e1;
  logic [15:0] e2;
  logic [31:0] an;
  logic [31:0] pc_ext;
  assign e0 = ext_at(3'h0);
  assign e1 = ext_at(3'h1);
  assign e2 = ext_at(3'h2);
  assign an = gpr_q[{1'b1, regf}];
  assign pc_ext = pc_q + {28'h000_0000, start_q, 1'b0};

  assign dec.ext  = e0;
  assign dec.xval = gpr_q[e0[`EAG_X_REG]];
  assign dec.mode = mode;
  assign dec.regf = regf;

  // combinational address forming
  logic [31:0] ea_d;
  logic [31:0] ptr_d;
  logic [31:0] add_d;
  logic [31:0] imm_d;
  logic [31:0] upd_d;
  logic [31:0] base;
  logic [31:0] bd;
  logic [31:0] od;
  logic [31:0] idx;
  logic [31:0] inc;
  logic [2:0]  bdn;
  logic [2:0]  nw_d;
  logic        ind_d;
  logic        prog_d;
  logic        isreg_d;
  logic        bad;

  always_comb begin
    ea_d    = '0;
    ptr_d   = '0;
    add_d   = '0;
    imm_d   = '0;
    upd_d   = an;
    bd      = '0;
    od      = '0;
    bdn     = 3'h0;
    nw_d    = 3'h0;
    ind_d   = 1'b0;
    prog_d  = 1'b0;
    isreg_d = 1'b0;
    bad     = 1'b0;
    case (size_q)
      SZ_BYTE: inc = (regf == `EAG_SP_REG) ? 32'h0000_0002
                                           : 32'h0000_0001;
      SZ_WORD: inc = 32'h0000_0002;
      default: inc = 32'h0000_0004;
    endcase
    base = an;
    // absolute forms are data space; pc-relative and immediate are not
    if (mode == `EAG_M_SPEC && regf != `EAG_S_ABSW
        && regf != `EAG_S_ABSL) begin
      base   = pc_ext;
      prog_d = 1'b1;
    end
    if (e0[`EAG_X_BS]) begin
      base = '0;
    end
    idx = e0[`EAG_X_IS] ? '0 : dec.idx;
    case (e0[`EAG_X_BDSZ])
      `EAG_SZ_NULL: bdn = 3'h0;
      `EAG_SZ_WORD: begin
        bd  = sext16(e1);
        bdn = 3'h1;
      end
      `EAG_SZ_LONG: begin
        bd  = {e1, e2};
        bdn = 3'h2;
      end
      default: bdn = 3'h0;
    endcase
    case (e0[1:0])
      `EAG_SZ_WORD: od = sext16(ext_at(3'(bdn + 3'h1)));
      `EAG_SZ_LONG: od = {ext_at(3'(bdn + 3'h1)),
                          ext_at(3'(bdn + 3'h2))};
      default:      od = '0;
    endcase
    case (mode)
      `EAG_M_DREG,
      `EAG_M_AREG: isreg_d = 1'b1;
      `EAG_M_IND:  ea_d = an;
      `EAG_M_POST: begin
        ea_d  = an;
        upd_d = an + inc;
      end
      `EAG_M_PRE: begin
        ea_d  = an - inc;
        upd_d = an - inc;
      end
      `EAG_M_DISP: begin
        ea_d = an + sext16(e0);
        nw_d = 3'h1;
      end
      `EAG_M_INDEX,
      `EAG_M_SPEC: begin
        case ({mode == `EAG_M_SPEC, (mode == `EAG_M_SPEC) ? regf : 3'h0})
          {1'b1, `EAG_S_ABSW}: begin
            ea_d = sext16(e0);
            nw_d = 3'h1;
          end
          {1'b1, `EAG_S_ABSL}: begin
            ea_d = {e0, e1};
            nw_d = 3'h2;
          end
          {1'b1, `EAG_S_PCD}: begin
            ea_d = pc_ext + sext16(e0);
            nw_d = 3'h1;
          end
          {1'b1, `EAG_S_IMM}: begin
            ea_d = pc_ext;
            case (size_q)
              SZ_BYTE: imm_d = {24'h00_0000, e0[7:0]};
              SZ_WORD: imm_d = {16'h0000, e0};
              default: imm_d = {e0, e1};
            endcase
            nw_d = (size_q == SZ_BYTE || size_q == SZ_WORD) ? 3'h1
                                                            : 3'h2;
          end
          {1'b1, `EAG_S_PCX},
          {1'b0, 3'h0}: begin
            if (!e0[`EAG_X_FULL]) begin
              ea_d = (mode == `EAG_M_SPEC ? pc_ext : an)
                     + sext8(e0[`EAG_X_D8]) + dec.idx;
              nw_d = 3'h1;
            end else begin
              nw_d = 3'(bdn + 3'h1);
              // size code only means something in the full format
              bad  = bad | (e0[`EAG_X_BDSZ] == `EAG_SZ_RSV);
              ea_d = base + bd + idx;
              if (e0[`EAG_X_IIS] != 3'h0) begin
                ind_d = 1'b1;
                bad   = bad | (e0[`EAG_X_IIS] == `EAG_IIS_RSV)
                        | (e0[`EAG_X_IS] & e0[2]);
                ptr_d = e0[2] ? base + bd : base + bd + idx;
                add_d = e0[2] ? od + idx : od;
                nw_d  = 3'(bdn + 3'h1 + ((e0[1:0] == `EAG_SZ_LONG)
                        ? 3'h2 : {2'h0, e0[1]}));
                ea_d  = '0;
              end
            end
          end
          default: bad = 1'b1;
        endcase
      end
      default: bad = 1'b1;
    endcase
  end

  // wishbone decode
  logic        acc;
  logic        wr;
  logic        idle;
  logic        go;
  assign acc  = wb_cyc & wb_stb & ~wb_ack;
  assign wr   = acc & wb_we;
  assign idle = (state_q == ST_IDLE);
  assign go   = wr & idle & (wb_adr == `EAG_A_CTRL)
                & wb_sel[0] & wb_wdata[`EAG_C_GO];

  // operand loads; ignored while a calculation runs
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      opw_q   <= 6'h00;
      pc_q    <= 32'h0000_0000;
      wr_q    <= 1'b0;
      size_q  <= SZ_BYTE;
      start_q <= 3'h0;
    end else if (wr & idle) begin
      case (wb_adr)
        `EAG_A_CTRL: begin
          if (wb_sel[0]) begin
            wr_q    <= wb_wdata[`EAG_C_WR];
            size_q  <= eag_size_t'(wb_wdata[`EAG_C_SIZE]);
            start_q <= wb_wdata[`EAG_C_START];
          end
        end
        `EAG_A_OPW: opw_q <= 6'(merge({26'h0, opw_q}, wb_wdata, wb_sel));
        `EAG_A_PC:  pc_q  <= merge(pc_q, wb_wdata, wb_sel);
        default: ;
      endcase
    end
  end

  // extension and general register stores
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      for (int i = 0; i < NEXT; i++) ext_q[i] <= 16'h0000;
      for (int i = 0; i < NGPR; i++) gpr_q[i] <= 32'h0000_0000;
    end else if (wr & idle) begin
      if (wb_adr[7:5] == 3'h1 && wb_adr[4:2] < 3'(NEXT)) begin
        ext_q[wb_adr[4:2]] <= 16'(merge({16'h0, ext_q[wb_adr[4:2]]},
                                        wb_wdata, wb_sel));
      end
      if (wb_adr[7:6] == 2'h1) begin
        gpr_q[wb_adr[5:2]] <= merge(gpr_q[wb_adr[5:2]], wb_wdata,
                                    wb_sel);
      end
    end
  end

  // calculation sequence
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_q  <= ST_IDLE;
      done_q   <= 1'b0;
      ea_q     <= 32'h0000_0000;
      imm_q    <= 32'h0000_0000;
      upd_q    <= 32'h0000_0000;
      add_q    <= 32'h0000_0000;
      fault_q  <= 1'b0;
      prog_q   <= 1'b0;
      isreg_q  <= 1'b0;
      ind_q    <= 1'b0;
      cls_q    <= '0;
      nw_q     <= 3'h0;
      ea_valid <= 1'b0;
    end else begin
      ea_valid <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (go) begin
            state_q <= ST_CALC;
            done_q  <= 1'b0;
          end
        end
        ST_CALC: begin
          ea_q    <= ea_d;
          imm_q   <= imm_d;
          upd_q   <= upd_d;
          add_q   <= add_d;
          prog_q  <= prog_d;
          isreg_q <= isreg_d;
          ind_q   <= ind_d;
          cls_q   <= dec.cls;
          nw_q    <= nw_d;
          fault_q <= bad | (wr_q & (prog_d | ~dec.cls.alterable));
          if (ind_d & ~bad) begin
            state_q <= ST_PTR;
          end else begin
            state_q  <= ST_IDLE;
            done_q   <= 1'b1;
            ea_valid <= 1'b1;
          end
        end
        ST_PTR: begin
          if (ptr_ack) begin
            ea_q     <= ptr_data + add_q;
            state_q  <= ST_IDLE;
            done_q   <= 1'b1;
            ea_valid <= 1'b1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // pointer read request
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ptr_req  <= 1'b0;
      ptr_addr <= 32'h0000_0000;
    end else if (state_q == ST_CALC && ind_d && !bad) begin
      ptr_req  <= 1'b1;
      ptr_addr <= ptr_d;
    end else if (ptr_ack) begin
      ptr_req  <= 1'b0;
    end
  end

  assign ea_addr  = ea_q;
  assign ea_prog  = prog_q;
  assign ea_fault = fault_q;

  // bus answer, one wait state; unmapped reads as zero
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      wb_ack   <= 1'b0;
      wb_rdata <= 32'h0000_0000;
    end else begin
      wb_ack   <= acc;
      wb_rdata <= 32'h0000_0000;
      if (acc & ~wb_we) begin
        case (wb_adr)
          `EAG_A_CTRL: wb_rdata <= {25'h0, start_q, size_q, wr_q, 1'b0};
          `EAG_A_OPW:  wb_rdata <= {26'h0, opw_q};
          `EAG_A_PC:   wb_rdata <= pc_q;
          `EAG_A_STAT: wb_rdata <= {19'h0, nw_q, cls_q, ind_q, isreg_q,
                                    prog_q, fault_q, done_q, ~idle};
          `EAG_A_EA:   wb_rdata <= ea_q;
          `EAG_A_IMM:  wb_rdata <= imm_q;
          `EAG_A_UPD:  wb_rdata <= upd_q;
          default: begin
            if (wb_adr[7:5] == 3'h1 && wb_adr[4:2] < 3'(NEXT)) begin
              wb_rdata <= {16'h0, ext_q[wb_adr[4:2]]};
            end
            if (wb_adr[7:6] == 2'h1) begin
              wb_rdata <= gpr_q[wb_adr[5:2]];
            end
          end
        endcase
      end
    end
  end
endmodule : eag_top

// ---- sim/eag_top_chk.sv ----
/*
 * Port-level concurrent checks for the effective-address generator.
 * Assumes binding onto eag_top; one clock, sync active-low reset.
 */
`timescale 1ns/1ns
module eag_top_chk (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rstn,
  // wishbone slave
  input wire logic        wb_cyc,
  input wire logic        wb_stb,
  input wire logic        wb_we,
  input wire logic [7:0]  wb_adr,
  input wire logic [3:0]  wb_sel,
  input wire logic [31:0] wb_wdata,
  input wire logic [31:0] wb_rdata,
  input wire logic        wb_ack,
  // pointer fetch
  input wire logic        ptr_req,
  input wire logic [31:0] ptr_addr,
  input wire logic        ptr_ack,
  input wire logic [31:0] ptr_data,
  // operand access unit
  input wire logic        ea_valid,
  input wire logic [31:0] ea_addr,
  input wire logic        ea_prog,
  input wire logic        ea_fault
);
  logic go_w;
  logic wr_q;

  default clocking cb_clk @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // go strobe as seen on the bus; only valid while the block is idle
  assign go_w = wb_cyc && wb_stb && !wb_ack && wb_we &&
                wb_adr[7:2] == 6'h00 && wb_sel[0] && wb_wdata[0];

  always_ff @(posedge core_clk) begin
    if (!rstn) wr_q <= 1'b0;
    else if (go_w) wr_q <= wb_wdata[1];
  end

  property p_ack_next;
    wb_cyc && wb_stb && !wb_ack |=> wb_ack;
  endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("ack missing after request");
  property p_ack_pulse;
    wb_ack |=> !wb_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  property p_ack_cause;
    $rose(wb_ack) |-> $past(wb_stb);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  property p_go_lat;
    go_w |-> ##2 (ea_valid || ptr_req);
  endproperty
  a_go_lat: assert property (p_go_lat)
    else $error("result late after go");
  property p_valid_pulse;
    ea_valid |=> !ea_valid;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse)
    else $error("result strobe too long");
  property p_ptr_hold;
    ptr_req && !ptr_ack |=> ptr_req && $stable(ptr_addr);
  endproperty
  a_ptr_hold: assert property (p_ptr_hold)
    else $error("pointer request not held");
  property p_ptr_end;
    ptr_req && ptr_ack |=> !ptr_req && ea_valid;
  endproperty
  a_ptr_end: assert property (p_ptr_end)
    else $error("pointer answer not used");
  property p_ptr_start;
    $rose(ptr_req) |-> $past(go_w, 2);
  endproperty
  a_ptr_start: assert property (p_ptr_start)
    else $error("pointer request at wrong time");
  property p_wr_fault;
    ea_valid && ea_prog && wr_q |-> ea_fault;
  endproperty
  a_wr_fault: assert property (p_wr_fault)
    else $error("write to program space not refused");
endmodule : eag_top_chk

bind eag_top eag_top_chk u_chk (
  .core_clk(core_clk), .rstn(rstn), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
  .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_wdata(wb_wdata),
  .wb_rdata(wb_rdata), .wb_ack(wb_ack), .ptr_req(ptr_req),
  .ptr_addr(ptr_addr), .ptr_ack(ptr_ack), .ptr_data(ptr_data),
  .ea_valid(ea_valid), .ea_addr(ea_addr), .ea_prog(ea_prog),
  .ea_fault(ea_fault));

// ---- sim/tb.sv ----
/*
 * Self-checking bench for the effective-address generator.
 * Assumes eag_top alone; the bench is bus master and pointer memory.
 */
`timescale 1ns/1ns
module tb;
  logic        core_clk = 1'b0;
  logic        rstn     = 1'b0;
  logic        wb_cyc   = 1'b0;
  logic        wb_stb   = 1'b0;
  logic        wb_we    = 1'b0;
  logic [7:0]  wb_adr   = 8'h00;
  logic [3:0]  wb_sel   = 4'hf;
  logic [31:0] wb_wdata = 32'h0000_0000;
  logic        ptr_ack  = 1'b0;
  logic [31:0] ptr_data = 32'h0000_0000;
  logic [31:0] wb_rdata, ptr_addr, ea_addr, r_ea, rd;
  logic        wb_ack, ptr_req, ea_valid, ea_prog, ea_fault, r_prog, r_flt;
  int          n_mismatch = 0;
  int          n_checks   = 0;
  int          n_valid    = 0;

  always #5 core_clk = ~core_clk;

  // result strobe lasts one cycle; catch it whatever the bench is doing
  always @(posedge core_clk) begin
    if (ea_valid === 1'b1) begin
      n_valid <= n_valid + 1;
      r_ea    <= ea_addr;
      r_prog  <= ea_prog;
      r_flt   <= ea_fault;
    end
  end

  eag_top u_dut (.core_clk(core_clk), .rstn(rstn), .wb_cyc(wb_cyc),
    .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
    .wb_wdata(wb_wdata), .wb_rdata(wb_rdata), .wb_ack(wb_ack),
    .ptr_req(ptr_req), .ptr_addr(ptr_addr), .ptr_ack(ptr_ack),
    .ptr_data(ptr_data), .ea_valid(ea_valid), .ea_addr(ea_addr),
    .ea_prog(ea_prog), .ea_fault(ea_fault));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= we;
    wb_adr   <= a;
    wb_wdata <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    rd = wb_rdata;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (wb_ack !== 1'b1) begin
      n_mismatch++;
      report_and_stop();
    end
    @(posedge core_clk);
  endtask : wb

  task automatic ext(input logic [2:0] k, input logic [15:0] v);
    wb(1'b1, 8'h20 + {3'h0, k, 2'h0}, {16'h0000, v});
  endtask : ext

  task automatic gpr(input logic [3:0] r, input logic [31:0] v);
    wb(1'b1, 8'h40 + {2'h0, r, 2'h0}, v);
  endtask : gpr

  // cb: ctrl bits 6:1, go added here; answers any pointer fetch
  task automatic run(input logic [5:0] ow, input logic [6:0] cb,
                     input logic [31:0] pa, input logic [31:0] pv);
    int n;
    int n0;
    n  = 0;
    n0 = n_valid;
    wb(1'b1, 8'h04, {26'h0, ow});
    wb(1'b1, 8'h00, {25'h0, cb | 7'h01});
    do begin
      @(posedge core_clk);
      n++;
      if (ptr_ack === 1'b1) ptr_ack <= 1'b0;
      else if (ptr_req === 1'b1) begin
        chk(ptr_addr, pa);
        ptr_ack  <= 1'b1;
        ptr_data <= pv;
      end
    end while (n_valid == n0 && n < 20);
    if (n_valid == n0) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask : run

  task automatic ck3(input logic [31:0] e, input logic p, input logic f);
    chk(r_ea, e);
    chk(32'(r_prog), 32'(p));
    chk(32'(r_flt), 32'(f));
  endtask : ck3

  task automatic t_regs();
    wb(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h0000_0000);
    wb(1'b1, 8'h10, 32'hdead_beef);
    wb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0000_0000);
    wb(1'b1, 8'h1c, 32'hdead_beef);
    wb(1'b0, 8'h1c, 32'h0);
    chk(rd, 32'h0000_0000);
    wb(1'b1, 8'h00, 32'h0000_007e);
    wb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0000_007e);
    $display("t_regs done");
  endtask : t_regs

  task automatic t_modes();
    logic [31:0] eat [7];
    logic [3:0]  clt [7];
    eat = '{32'h0, 32'h0, 32'h2000, 32'h2000, 32'h1ffc, 32'h5008, 32'h2007};
    clt = '{4'h9, 4'h1, 4'hf, 4'hd, 4'hd, 4'hf, 4'hf};
    ext(3'h0, 16'h3008);
    for (int m = 0; m < 7; m++) begin
      gpr(4'ha, 32'h0000_2000);
      run({m[2:0], 3'h2}, 7'h08, 32'h0, 32'h0);
      chk(r_ea, eat[m]);
      wb(1'b0, 8'h0c, 32'h0);
      chk(32'(rd[9:6]), 32'(clt[m]));
      chk(32'(rd[4]), 32'(m < 2));
      if (m == 3 || m == 4) begin
        wb(1'b0, 8'h18, 32'h0);
        chk(rd, (m == 3) ? 32'h0000_2004 : 32'h0000_1ffc);
      end
    end
    // stack pointer keeps word alignment on byte steps
    run(6'h27, 7'h00, 32'h0, 32'h0);
    chk(r_ea, 32'h0000_3ffe);
    $display("t_modes done");
  endtask : t_modes

  task automatic t_spec();
    ext(3'h1, 16'h8000);
    run(6'h38, 7'h18, 32'h0, 32'h0);
    ck3(32'hffff_8000, 1'b0, 1'b0);
    ext(3'h1, 16'h1234);
    ext(3'h2, 16'h5678);
    run(6'h39, 7'h18, 32'h0, 32'h0);
    ck3(32'h1234_5678, 1'b0, 1'b0);
    ext(3'h1, 16'hfffe);
    run(6'h3a, 7'h18, 32'h0, 32'h0);
    ck3(32'h0000_1000, 1'b1, 1'b0);
    run(6'h3a, 7'h1a, 32'h0, 32'h0);
    ck3(32'h0000_1000, 1'b1, 1'b1);
    ext(3'h1, 16'h3008);
    run(6'h3b, 7'h18, 32'h0, 32'h0);
    ck3(32'h0000_1009, 1'b1, 1'b0);
    ext(3'h1, 16'h12ab);
    run(6'h3c, 7'h10, 32'h0, 32'h0);
    wb(1'b0, 8'h14, 32'h0);
    chk(rd, 32'h0000_00ab);
    run(6'h3c, 7'h14, 32'h0, 32'h0);
    wb(1'b0, 8'h14, 32'h0);
    chk(rd, 32'h0000_12ab);
    run(6'h3c, 7'h18, 32'h0, 32'h0);
    ck3(32'h0000_1002, 1'b1, 1'b0);
    wb(1'b0, 8'h14, 32'h0);
    chk(rd, 32'h12ab_5678);
    wb(1'b0, 8'h0c, 32'h0);
    chk(32'(rd[9:6]), 32'h0000_000c);
    // immediate is not alterable, so a write is refused
    run(6'h3c, 7'h1a, 32'h0, 32'h0);
    chk(32'(r_flt), 32'h0000_0001);
    run(6'h3d, 7'h18, 32'h0, 32'h0);
    chk(32'(r_flt), 32'h0000_0001);
    $display("t_spec done");
  endtask : t_spec

  task automatic t_index();
    logic [31:0] iv;
    for (int k = 0; k < 8; k++) begin
      ext(3'h0, {4'h3, k[2], k[1:0], 9'h010});
      run(6'h32, 7'h08, 32'h0, 32'h0);
      iv = k[2] ? 32'h0001_ffff : 32'hffff_ffff;
      chk(r_ea, 32'h0000_2010 + (iv << k[1:0]));
    end
    ext(3'h0, 16'hbaf0);
    run(6'h32, 7'h08, 32'h0, 32'h0);
    chk(r_ea, 32'h0000_21f0);
    wb(1'b0, 8'h4c, 32'h0);
    chk(rd, 32'h0001_ffff);
    $display("t_index done");
  endtask : t_index

  task automatic t_full();
    ext(3'h0, 16'h01f0);
    ext(3'h1, 16'h8765);
    ext(3'h2, 16'h4321);
    run(6'h3b, 7'h08, 32'h0, 32'h0);
    ck3(32'h8765_4321, 1'b1, 1'b0);
    ext(3'h1, 16'h3b20);
    ext(3'h2, 16'hfff0);
    run(6'h3b, 7'h18, 32'h0, 32'h0);
    ck3(32'h0004_0ff0, 1'b1, 1'b0);
    ext(3'h0, 16'h3190);
    run(6'h32, 7'h08, 32'h0, 32'h0);
    ck3(32'hffff_ffff, 1'b0, 1'b0);
    $display("t_full done");
  endtask : t_full

  task automatic t_ind();
    ext(3'h0, 16'hb9b5);
    ext(3'h1, 16'h0000);
    ext(3'h2, 16'h3000);
    run(6'h32, 7'h08, 32'h0000_3000, 32'h0005_0000);
    ck3(32'h0005_0100, 1'b0, 1'b0);
    wb(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h0000_0fe2);
    ext(3'h0, 16'h3121);
    ext(3'h1, 16'h0010);
    run(6'h32, 7'h08, 32'h0000_200f, 32'h0000_7000);
    ck3(32'h0000_7000, 1'b0, 1'b0);
    // refused form must skip the fetch; a stray request mismatches
    ext(3'h0, 16'h3165);
    run(6'h32, 7'h08, 32'hffff_ffff, 32'h0);
    chk(32'(r_flt), 32'h0000_0001);
    $display("t_ind done");
  endtask : t_ind

  initial begin
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    t_regs();
    wb(1'b1, 8'h08, 32'h0000_1000);
    gpr(4'h3, 32'h0001_ffff);
    gpr(4'hb, 32'h0000_0100);
    gpr(4'hf, 32'h0000_4000);
    t_modes();
    t_spec();
    t_index();
    t_full();
    t_ind();
    report_and_stop();
  end
endmodule : tb
